// file: rtl/irq_ctrl_regs.svh
`ifndef IRQ_CTRL_REGS_SVH
`define IRQ_CTRL_REGS_SVH

// ----------------------------------------
// Sizes and reset values
// ----------------------------------------
`define NUM_SRC 32
`define SRC_IDX_W 5
`define VEC_W 32
`define PRIO_W 3
`define STACK_DEPTH 8
`define PTR_W 4
`define PRIO_MAX 3'h7
`define VEC_RESET 32'h00000000
`define FORCE_RESET 32'h00000000
// Source type encoding: bit1 = polarity high, bit0 = edge
`define TYPE_EDGE_BIT 0
`define TYPE_HIGH_BIT 1

`endif

// file: rtl/irq_ctrl_pkg.sv
package irq_ctrl_pkg;
  typedef logic [31:0] src_vec_t;
  typedef logic [31:0] vector_t;
  typedef logic [2:0] prio_t;

  // Per-source mode: priority field and two-bit source type
  typedef struct packed {
    logic [1:0] src_type;
    prio_t priority_field;
  } source_mode_s;

  // Register-port access strobes from the core
  typedef struct packed {
    logic normal_vector_rd;
    logic normal_vector_wr;
    logic fast_vector_rd;
    logic end_of_irq_wr;
    logic force_enable_wr;
    logic force_disable_wr;
    logic clear_wr;
    logic enable_wr;
    logic disable_wr;
  } access_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HELD = 2'b01
  } ack_state_e;
endpackage : irq_ctrl_pkg

// file: rtl/src_qualify.sv
`timescale 1ns/1ns
`include "irq_ctrl_regs.svh"
// Per-source edge or level qualification with pin synchroniser
module src_qualify (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic raw_i,
  input wire logic [1:0] src_type_i,
  output logic level_o,
  output logic edge_o
);
  logic s1_q, s2_q, s3_q;
  logic prev_q;
  logic active_lvl;

  // Three-stage synchroniser; change counts when stages 2 and 3 agree
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      s1_q <= raw_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      prev_q <= (s2_q == s3_q) ? s3_q : prev_q;
    end
  end

  // Stable value flips polarity for low-active types
  assign active_lvl = ((s2_q == s3_q) ? s3_q : prev_q) ~^ src_type_i[`TYPE_HIGH_BIT];
  assign level_o = active_lvl;
  assign edge_o = active_lvl & ~(prev_q ~^ src_type_i[`TYPE_HIGH_BIT]);
endmodule : src_qualify

// file: rtl/prio_stack.sv
`timescale 1ns/1ns
`include "irq_ctrl_regs.svh"
// Priority-level stack with current level and source
module prio_stack (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic push_i,
  input wire irq_ctrl_pkg::prio_t push_prio_i,
  input wire logic [`SRC_IDX_W-1:0] push_src_i,
  input wire logic pop_i,
  output logic active_o,
  output irq_ctrl_pkg::prio_t level_o,
  output logic [`SRC_IDX_W-1:0] src_o
);
  import irq_ctrl_pkg::*;
  prio_t lvl_q [`STACK_DEPTH];
  logic [`SRC_IDX_W-1:0] src_q [`STACK_DEPTH];
  logic [`PTR_W-1:0] ptr_q;
  logic [`PTR_W-1:0] top;

  assign top = ptr_q - `PTR_W'(1);
  assign active_o = (ptr_q != '0);
  assign level_o = active_o ? lvl_q[top[2:0]] : '0;
  assign src_o = active_o ? src_q[top[2:0]] : '0;

  // Push wins when both arrive together unless the stack is full; a full stack drops the push and the pop proceeds
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ptr_q <= '0;
    end else if (push_i && ptr_q != `PTR_W'(`STACK_DEPTH)) begin
      lvl_q[ptr_q[2:0]] <= push_prio_i;
      src_q[ptr_q[2:0]] <= push_src_i;
      ptr_q <= ptr_q + `PTR_W'(1);
    end else if (pop_i && active_o) begin
      ptr_q <= top;
    end
  end
endmodule : prio_stack

// file: rtl/fast_irq_ctrl.sv
`timescale 1ns/1ns
`include "irq_ctrl_regs.svh"
// Behaviour
// - Fast vector read clears source 0 only when edge triggered, dropping fast line
// - Force enable and disable writes set or clear force status bits
// - Forced source still qualified but never raises normal request nor wins priority
// - Forced level source asserts fast line while active level sampled
// - Forced edge source asserts fast line when active edge detected
// - Forcing never changes the source 0 pending bit
// - Fast vector read always returns source vector 0
// - With forcing in use, fast vector read leaves source 0 pending
// - Normal vector read never clears a forced source
// - Source 0 keeps normal fast operation and contributes to fast line
// - Protect enable set to one selects protect mode
// - Normal mode vector read computes, returns, records, pushes and acknowledges
// - Protect mode read only computes, returns, records; write pushes and acknowledges
// - Protect mode stacking and current-source update happen on vector write
// - Protect mode reads alone leave context and current source unchanged
// - Normal mode vector write has no effect
// - Vector read with nothing pending returns spurious vector
// - Global mask holds both request lines inactive
// - End of interrupt pops current level, restoring previous
// - Normal sources have priority zero to seven; source 0 ignores it
module fast_irq_ctrl (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire irq_ctrl_pkg::src_vec_t src_raw_i,
  input wire irq_ctrl_pkg::source_mode_s [`NUM_SRC-1:0] source_mode_i,
  input wire irq_ctrl_pkg::vector_t [`NUM_SRC-1:0] source_vector_i,
  input wire irq_ctrl_pkg::vector_t spurious_vector_i,
  input wire irq_ctrl_pkg::access_s access_i,
  input wire irq_ctrl_pkg::src_vec_t wdata_i,
  input wire logic protect_enable_i,
  input wire logic global_mask_i,
  output logic normal_req_n_o,
  output logic fast_req_n_o,
  output logic wake_o,
  output irq_ctrl_pkg::vector_t normal_vector_port_o,
  output irq_ctrl_pkg::vector_t fast_vector_read_o,
  output irq_ctrl_pkg::src_vec_t force_status_o,
  output irq_ctrl_pkg::src_vec_t pending_status_o,
  output irq_ctrl_pkg::src_vec_t enable_status_o,
  output logic [`SRC_IDX_W-1:0] current_source_status_o
);
  import irq_ctrl_pkg::*;

  // ----------------------------------------
  // Source qualification
  // ----------------------------------------
  src_vec_t lvl, edg, is_edge;
  src_vec_t force_q, pend_q, en_q;
  logic [`SRC_IDX_W-1:0] rec_src_q, cur_src_q;
  prio_t rec_prio_q;
  logic rec_valid_q;
  logic normal_q, fast_q, wake_q;
  vector_t nvec_q, fvec_q;

  for (genvar i = 0; i < `NUM_SRC; i++) begin : g_src
    src_qualify u_q (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .raw_i(src_raw_i[i]),
      .src_type_i(source_mode_i[i].src_type),
      .level_o(lvl[i]),
      .edge_o(edg[i])
    );
    assign is_edge[i] = source_mode_i[i].src_type[`TYPE_EDGE_BIT];
  end

  // ----------------------------------------
  // Priority resolution over normal sources
  // ----------------------------------------
  // Bit 0 and forced sources are kept out of the normal pool
  function automatic logic [`SRC_IDX_W:0] pick(input src_vec_t cand,
      input source_mode_s [`NUM_SRC-1:0] m);
    logic [`SRC_IDX_W:0] best;
    best = '0;
    for (int k = 1; k < `NUM_SRC; k++) begin
      if (cand[k] && (!best[`SRC_IDX_W] ||
          m[k].priority_field > m[best[`SRC_IDX_W-1:0]].priority_field)) begin
        best = {1'b1, `SRC_IDX_W'(k)};
      end
    end
    return best;
  endfunction : pick

  logic stk_active;
  prio_t stk_level;
  logic [`SRC_IDX_W-1:0] stk_src;
  src_vec_t normal_cand;
  logic [`SRC_IDX_W:0] winner;
  logic win_valid, win_above;
  prio_t win_prio;

  assign normal_cand = pend_q & en_q & ~force_q & ~src_vec_t'(1);
  assign winner = pick(normal_cand, source_mode_i);
  assign win_prio = source_mode_i[winner[`SRC_IDX_W-1:0]].priority_field;
  assign win_valid = winner[`SRC_IDX_W];
  assign win_above = win_valid && (!stk_active || win_prio > stk_level);

  // ----------------------------------------
  // Vector access decode
  // ----------------------------------------
  logic nrd, nwr, frd, ack, rd_ack, wr_ack;
  logic force_used;
  assign nrd = access_i.normal_vector_rd;
  assign nwr = access_i.normal_vector_wr;
  assign frd = access_i.fast_vector_rd;
  assign rd_ack = nrd && !protect_enable_i && win_above;
  assign wr_ack = nwr && protect_enable_i && rec_valid_q;
  assign ack = rd_ack || wr_ack;
  assign force_used = |(force_q & ~src_vec_t'(1));

  // Pending clear on acknowledge: edge and not forced only
  src_vec_t ack_clr, fast_clr, pend_set, pend_clr;
  assign ack_clr = ack ? ((src_vec_t'(1) << (rd_ack ? winner[`SRC_IDX_W-1:0] : rec_src_q))
      & is_edge & ~force_q) : '0;
  assign fast_clr = (frd && is_edge[0] && !force_used) ? src_vec_t'(1) : '0;
  assign pend_set = (is_edge & edg) | (~is_edge & lvl);
  assign pend_clr = ack_clr | fast_clr | (access_i.clear_wr ? wdata_i : '0) | (~is_edge & ~lvl);

  prio_stack u_stack (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .push_i(ack),
    .push_prio_i(rd_ack ? win_prio : rec_prio_q),
    .push_src_i(rd_ack ? winner[`SRC_IDX_W-1:0] : rec_src_q),
    .pop_i(access_i.end_of_irq_wr),
    .active_o(stk_active),
    .level_o(stk_level),
    .src_o(stk_src)
  );

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  // Pending set beats clear so a same-cycle event is kept; for force and enable bits the clear write wins
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      force_q <= `FORCE_RESET;
      pend_q <= '0;
      en_q <= '0;
    end else begin
      force_q <= (force_q | (access_i.force_enable_wr ? wdata_i : '0))
          & ~(access_i.force_disable_wr ? wdata_i : '0);
      pend_q <= (pend_q & ~pend_clr) | pend_set;
      en_q <= (en_q | (access_i.enable_wr ? wdata_i : '0)) & ~(access_i.disable_wr ? wdata_i : '0);
    end
  end

  // Recorded interrupt: any normal vector read records, protect reads included
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rec_valid_q <= 1'b0;
      rec_src_q <= '0;
      rec_prio_q <= '0;
      cur_src_q <= '0;
    end else begin
      if (nrd) begin
        rec_valid_q <= win_above;
        rec_src_q <= winner[`SRC_IDX_W-1:0];
        rec_prio_q <= win_prio;
      end else if (wr_ack) begin
        rec_valid_q <= 1'b0;
      end
      cur_src_q <= ack ? (rd_ack ? winner[`SRC_IDX_W-1:0] : rec_src_q)
          : (access_i.end_of_irq_wr ? stk_src : cur_src_q);
    end
  end

  // ----------------------------------------
  // Request lines and read data
  // ----------------------------------------
  logic fast_cond, normal_cond, any_cond;
  assign fast_cond = (pend_q[0] & en_q[0]) | |(force_q & en_q & lvl & ~is_edge)
      | |(force_q & en_q & pend_q & is_edge);
  assign normal_cond = win_above && !(ack);
  assign any_cond = fast_cond | normal_cond;

  // Outputs registered; mask holds both lines high but not wake
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      normal_q <= 1'b1;
      fast_q <= 1'b1;
      wake_q <= 1'b0;
      nvec_q <= `VEC_RESET;
      fvec_q <= `VEC_RESET;
    end else begin
      normal_q <= !(normal_cond && !global_mask_i);
      fast_q <= !(fast_cond && !global_mask_i && !(|fast_clr));
      wake_q <= any_cond;
      if (nrd) begin
        nvec_q <= win_above ? source_vector_i[winner[`SRC_IDX_W-1:0]] : spurious_vector_i;
      end
      if (frd) begin
        fvec_q <= source_vector_i[0];
      end
    end
  end

  assign normal_req_n_o = normal_q;
  assign fast_req_n_o = fast_q;
  assign wake_o = wake_q;
  assign normal_vector_port_o = nvec_q;
  assign fast_vector_read_o = fvec_q;
  assign force_status_o = force_q;
  assign pending_status_o = pend_q;
  assign enable_status_o = en_q;
  assign current_source_status_o = cur_src_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_mask_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $past(global_mask_i) |-> (normal_req_n_o && fast_req_n_o)) else $error("mask did not hold lines");
  chk_fast_vec: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    frd |=> fast_vector_read_o == $past(source_vector_i[0])) else $error("fast vector not source 0");
  chk_protect_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (nrd && protect_enable_i && !nwr) |=> $stable(u_stack.ptr_q)) else $error("protect read stacked");
  chk_normal_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (nwr && !protect_enable_i && !nrd && !access_i.end_of_irq_wr) |=> $stable(u_stack.ptr_q))
    else $error("normal write stacked");
  chk_spurious_ret: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (nrd && !win_above) |=> normal_vector_port_o == $past(spurious_vector_i)) else $error("no spurious");
  chk_force_excl: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    win_valid |-> !force_q[winner[`SRC_IDX_W-1:0]]) else $error("forced source won priority");
  chk_force_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (access_i.force_enable_wr && !access_i.force_disable_wr) |=> ((force_q & $past(wdata_i)) == $past(wdata_i)))
    else $error("force bit not set");
  chk_fast_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (frd && force_used && !access_i.clear_wr && pend_q[0] && is_edge[0]) |=> pend_q[0])
    else $error("fast read cleared under forcing");
  chk_eoi_pop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (access_i.end_of_irq_wr && !ack && stk_active) |=> u_stack.ptr_q == $past(u_stack.ptr_q) - 4'h1)
    else $error("end of irq did not pop");
  // With no source forced, edge fast source drops its pending bit after a fast read, unless a new edge lands
  chk_fast_rd_clr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (frd && is_edge[0] && !force_used && !edg[0]) |=> !pending_status_o[0])
    else $error("fast read left edge source 0 pending");
  // Any unmasked contributor must show on the fast line one cycle later, outside a fast read
  chk_fast_line: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (fast_cond && !global_mask_i && !frd) |=> !fast_req_n_o)
    else $error("fast line not asserted");
  // End of interrupt restores the stacked source as the current one
  chk_eoi_restore: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (access_i.end_of_irq_wr && !ack) |=> current_source_status_o == $past(stk_src))
    else $error("end of irq did not restore source");
  cov_forced_fast: cover property (@(posedge clk_i) force_used && !fast_req_n_o);
  cov_forced_edge: cover property (@(posedge clk_i) |(force_q & is_edge & pend_q));
  cov_fast_read: cover property (@(posedge clk_i) frd && !force_used);
  cov_protect_ack: cover property (@(posedge clk_i) wr_ack);
  cov_spurious: cover property (@(posedge clk_i) nrd && !win_above);
endmodule : fast_irq_ctrl

// file: test/core_model.sv
`timescale 1ns/1ns
// Core side: takes one vector per request while go_i is high
module core_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic go_i,
  input wire logic protect_i,
  input wire logic fast_req_n_i,
  input wire logic normal_req_n_i,
  output logic fast_rd_o,
  output logic normal_rd_o,
  output logic normal_wr_o
);
  logic busy_q;
  // Busy until both lines are released, so a slow release is never read twice
  always_ff @(posedge clk_i) begin
    fast_rd_o <= 1'b0;
    normal_rd_o <= 1'b0;
    normal_wr_o <= normal_rd_o && protect_i;
    if (!rst_n_i) begin
      busy_q <= 1'b0;
      normal_wr_o <= 1'b0;
    end else if (busy_q) begin
      busy_q <= !(fast_req_n_i && normal_req_n_i);
    end else if (go_i && !fast_req_n_i) begin
      fast_rd_o <= 1'b1;
      busy_q <= 1'b1;
    end else if (go_i && !normal_req_n_i) begin
      normal_rd_o <= 1'b1;
      busy_q <= 1'b1;
    end
  end
endmodule : core_model

// file: test/tb_top.sv
`timescale 1ns/1ns
`include "irq_ctrl_regs.svh"
module tb_top;
  import irq_ctrl_pkg::*;
  localparam int NVR = 8, NVW = 7, FVR = 6, EOI = 5, FEN = 4, FDS = 3, CLR = 2, ENA = 1;
  logic clk_i = 1'b0, rst_n_i = 1'b0, prot = 1'b0, gmask = 1'b0, go = 1'b0;
  logic fast_rd, normal_rd, normal_wr, nrd_d = 1'b0, frd_d = 1'b0;
  logic nreq_n, freq_n, wake;
  logic [`SRC_IDX_W-1:0] cur, cs;
  src_vec_t src = '0, wdata = '0, force_st, pend, ena_st;
  source_mode_s [`NUM_SRC-1:0] mode;
  vector_t [`NUM_SRC-1:0] sv;
  vector_t spur, nvec, fvec;
  access_s acc = '0, mdl, acc_all;
  vector_t nq[$], fq[$];
  int failures = 0, tests_run = 0;

  always #10 clk_i = ~clk_i;
  assign mdl = '{normal_vector_rd: normal_rd, normal_vector_wr: normal_wr, fast_vector_rd: fast_rd, default: 1'b0};
  assign acc_all = access_s'(acc | mdl);

  fast_irq_ctrl dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .src_raw_i(src), .source_mode_i(mode),
    .source_vector_i(sv), .spurious_vector_i(spur), .access_i(acc_all), .wdata_i(wdata),
    .protect_enable_i(prot), .global_mask_i(gmask), .normal_req_n_o(nreq_n), .fast_req_n_o(freq_n),
    .wake_o(wake), .normal_vector_port_o(nvec), .fast_vector_read_o(fvec), .force_status_o(force_st),
    .pending_status_o(pend), .enable_status_o(ena_st), .current_source_status_o(cur));
  core_model core (.clk_i(clk_i), .rst_n_i(rst_n_i), .go_i(go), .protect_i(prot), .fast_req_n_i(freq_n),
    .normal_req_n_i(nreq_n), .fast_rd_o(fast_rd), .normal_rd_o(normal_rd), .normal_wr_o(normal_wr));

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t value mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    if (failures == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc
  // One-cycle command pulse, driven on the rising edge
  task automatic cmd(input logic [8:0] b, input src_vec_t d);
    @(posedge clk_i);
    acc <= access_s'(b);
    wdata <= d;
    @(posedge clk_i);
    acc <= '0;
  endtask : cmd
  // Bounded wait; pin synchroniser takes several cycles
  task automatic wait_line(input bit normal, input logic lvl);
    for (int i = 0; i < 12; i++) begin
      if ((normal ? nreq_n : freq_n) === lvl) return;
      cyc(1);
    end
    failures++;
    $display("[FAIL] %0t request line did not settle", $time);
    results();
  endtask : wait_line

  // Read data is settled by the falling edge after the sampling edge
  always @(posedge clk_i) begin
    nrd_d <= acc_all.normal_vector_rd;
    frd_d <= acc_all.fast_vector_rd;
  end
  always @(negedge clk_i) begin
    if (nrd_d) check(nvec, nq.size() > 0 ? nq.pop_front() : 32'hX);
    if (frd_d) check(fvec, fq.size() > 0 ? fq.pop_front() : 32'hX);
  end

  initial begin
    void'($urandom(32'h0C4D));
    foreach (sv[i]) sv[i] = $urandom();
    spur = $urandom();
    foreach (mode[i]) mode[i] = '{src_type: 2'b11, priority_field: 3'h0};
    mode[1] = '{src_type: 2'b10, priority_field: 3'h3};
    mode[2] = '{src_type: 2'b11, priority_field: 3'h5};
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    cmd(9'h1 << ENA, 32'h0000_0007);
    // Fast edge source taken by the core model
    fq.push_back(sv[0]);
    go <= 1'b1;
    src[0] <= 1'b1;
    wait_line(0, 1'b0);
    wait_line(0, 1'b1);
    go <= 1'b0;
    check(pend[0], 1'b0);
    src[0] <= 1'b0;
    // Global mask on a level source
    gmask <= 1'b1;
    src[1] <= 1'b1;
    cyc(8);
    check(nreq_n, 1'b1);
    check(wake, 1'b1);
    gmask <= 1'b0;
    wait_line(1, 1'b0);
    nq.push_back(sv[1]);
    cmd(9'h1 << NVR, '0);
    cyc(2);
    check(cur, 5'h01);
    check(nreq_n, 1'b1);
    src[1] <= 1'b0;
    // Let the level drop pass the pin synchroniser before the spurious read
    cyc(5);
    cmd(9'h1 << EOI, '0);
    // Nothing pending gives the spurious vector
    nq.push_back(spur);
    cmd(9'h1 << NVR, '0);
    cmd(9'h1 << EOI, '0);
    // Protect mode: repeated reads alone change nothing
    prot <= 1'b1;
    src[1] <= 1'b1;
    wait_line(1, 1'b0);
    cs = cur;
    nq.push_back(sv[1]);
    nq.push_back(sv[1]);
    cmd(9'h1 << NVR, '0);
    cmd(9'h1 << NVR, '0);
    cyc(2);
    check(cur, cs);
    check(nreq_n, 1'b0);
    nq.push_back(sv[1]);
    go <= 1'b1;
    wait_line(1, 1'b1);
    go <= 1'b0;
    check(cur, 5'h01);
    src[1] <= 1'b0;
    cmd(9'h1 << EOI, '0);
    prot <= 1'b0;
    // Normal mode write is ignored
    src[1] <= 1'b1;
    wait_line(1, 1'b0);
    cs = cur;
    cmd(9'h1 << NVW, '0);
    cyc(2);
    check(nreq_n, 1'b0);
    check(cur, cs);
    // Forcing moves the pending level source to the fast line
    cmd(9'h1 << FEN, 32'h0000_0006);
    cyc(1);
    check(force_st, 32'h0000_0006);
    wait_line(0, 1'b0);
    check(nreq_n, 1'b1);
    check(pend[0], 1'b0);
    fq.push_back(sv[0]);
    cmd(9'h1 << FVR, '0);
    cyc(2);
    check(freq_n, 1'b0);
    gmask <= 1'b1;
    cyc(3);
    check(freq_n, 1'b1);
    gmask <= 1'b0;
    src[1] <= 1'b0;
    cyc(3);
    wait_line(0, 1'b1);
    // Forced edge source is only cleared by the clear command
    src[2] <= 1'b1;
    cyc(2);
    src[2] <= 1'b0;
    wait_line(0, 1'b0);
    check(nreq_n, 1'b1);
    nq.push_back(spur);
    cmd(9'h1 << NVR, '0);
    cyc(2);
    check(pend[2], 1'b1);
    fq.push_back(sv[0]);
    cmd(9'h1 << FVR, '0);
    cyc(2);
    check(pend[2], 1'b1);
    check(freq_n, 1'b0);
    cmd(9'h1 << CLR, 32'h0000_0004);
    wait_line(0, 1'b1);
    cmd(9'h1 << EOI, '0);
    cmd((9'h1 << FEN) | (9'h1 << FDS), 32'h0000_0008);
    cyc(1);
    check(force_st, 32'h0000_0006);
    cmd(9'h1 << FDS, 32'h0000_0006);
    cyc(1);
    check(force_st, 32'h0000_0000);
    check(nq.size() + fq.size(), 32'h0);
    results();
  end
endmodule : tb_top
